// ==== core/sbs_burst_ctr.sv ====
`timescale 1ns/1ns
// ============================================================
// Two-bit burst counter with linear or interleaved address order.
module sbs_burst_ctr
	import sbs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic load,
	input wire logic advance,
	input wire logic [BURST_W-1:0] start,
	input wire logic interleaved,
	// Low address bits that the coming edge will register
	output logic [BURST_W-1:0] low_next
);
	logic [BURST_W-1:0] start_q;
	logic [BURST_W-1:0] offs_q;
	logic [BURST_W-1:0] offs_inc;
	logic [BURST_W-1:0] low_now;
	logic [BURST_W-1:0] low_step;

	// Order function: linear adds the offset, interleaved flips bits with it.
	function automatic logic [BURST_W-1:0] seq_bits(input logic [BURST_W-1:0] s, input logic [BURST_W-1:0] o,
		input logic il);
		seq_bits = il ? (s ^ o) : BURST_W'(s + o);
	endfunction

	// The offset wraps inside two bits, so the fifth beat repeats the first.
	assign offs_inc = BURST_W'(offs_q + 2'h1); // [R17]
	assign low_now = seq_bits(start_q, offs_q, interleaved);
	assign low_step = seq_bits(start_q, offs_inc, interleaved);
	assign low_next = load ? start : (advance ? low_step : low_now);

	// A load restarts the burst; an advance steps it by one beat.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			start_q <= RST_BURST;
			offs_q <= RST_BURST;
		end
		else if (load)
		begin
			start_q <= start; // [R2]
			offs_q <= RST_BURST;
		end
		else if (advance)
		begin
			offs_q <= offs_inc; // [R5]
		end
	end
endmodule

// ==== core/sbs_pkg.sv ====
// ============================================================
// Shared constants for the synchronous burst SRAM port control.
package sbs_pkg;
	// Default widths: full address, byte lanes, bits per lane (8 data + 1 parity).
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	// Burst counter width and the position of the low address field.
	localparam int BURST_W = 2;
	localparam int LOW_LSB = 0;
	// Strap level that selects the linear order; the other level selects interleaved.
	localparam logic ORDER_LINEAR = 1'b0;
	// Reset values.
	localparam logic [BURST_W-1:0] RST_BURST = 2'h0;
	localparam logic RST_OE_N = 1'b1;
	localparam logic RST_STRAP = 1'b1;

	// Access state of the port after each clock edge.
	typedef enum logic [1:0] {SBS_DESEL, SBS_READ, SBS_WRITE} sbs_state_t;
endpackage

// ==== core/sbs_port_ctrl.sv ====
`timescale 1ns/1ns
// ============================================================
// Overview of operation
// [R1] The address is captured on an edge only when a strobe is honoured and all three chip enables are active.
// [R2] The two low captured address bits load a two-bit burst counter that supplies the low access address.
// [R3] The four active-low byte selects write their lanes only when the byte write enable is low on that edge.
// [R4] A low global write writes every lane and overrides the byte selects and byte write enable.
// [R5] Each edge with the advance input low during a burst steps the burst counter to the next address.
// [R6] The processor strobe is disregarded on any edge where the first chip enable is high.
// [R7] The host selects the part by driving the first chip enable low and the second high.
// [R8] The third chip enable is active low and joins the other two in the selection condition.
// [R9] In the ball-grid variant the third chip enable counts as always active.
// [R10] Chip enables are looked at only on edges that load a new external address.
// [R11] Output enable low lets the data pins drive; high leaves them floating as inputs.
// [R12] Output enable is ignored during the first clock of a read that follows the deselected state.
// [R13] When both strobes are low together, only the processor strobe is acted upon.
// [R14] A low burst order strap selects linear order; a high one selects interleaved order.
// [R15] The host holds byte write enable low for any byte-granular write.
// [R16] The data and parity pins float during write data, in the first clock out of deselect, and while deselected.
// [R17] The burst counter wraps within two bits, so a burst visits at most four locations.
module sbs_port_ctrl
	import sbs_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int NL = LANES,
	parameter int LW = LANE_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Address and strobes
	input wire logic [AW-3:0] addr_upper,
	input wire logic addr_bit_one,
	input wire logic addr_bit_zero,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	// Chip enables, package strap and burst order strap
	input wire logic chip_enable_one_n,
	input wire logic chip_enable_two,
	input wire logic chip_enable_three_n,
	input wire logic bga_package,
	input wire logic burst_order_strap,
	// Write qualifiers
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic byte_lane_a_write_sel_n,
	input wire logic byte_lane_b_write_sel_n,
	input wire logic byte_lane_c_write_sel_n,
	input wire logic byte_lane_d_write_sel_n,
	// Data pins, parity bit is the top bit of each lane
	input wire logic output_enable_n,
	input wire logic [NL*LW-1:0] dq_in,
	output logic [NL*LW-1:0] dq_out_q,
	output logic dq_oe_n_q,
	// Memory core side
	output logic [AW-1:0] core_addr_q,
	output logic [NL-1:0] core_byte_we_q,
	output logic [NL*LW-1:0] core_wdata_q,
	output logic core_rd_q,
	input wire logic [NL*LW-1:0] core_rdata
);
	sbs_state_t state_q;
	sbs_state_t state_d;
	logic interleaved_q;
	logic strap_taken_q;
	logic rd_pend_q;
	logic ce_ok;
	logic proc_load;
	logic ctrl_load;
	logic load;
	logic active_q;
	logic sel_next;
	logic advance;
	logic wr_now;
	logic rd_now;
	logic first_clk;
	logic [NL-1:0] bw_sel_n;
	logic [NL-1:0] lanes;
	logic [BURST_W-1:0] low_next;
	logic [AW-3:0] upper_next;

	// ============================================================
	// Selection and strobe decode

	// The third enable drops out on the ball-grid variant.
	assign ce_ok = !chip_enable_one_n && chip_enable_two && (bga_package || !chip_enable_three_n); // [R7] [R8] [R9]
	// A processor strobe with the first enable high is not a strobe at all.
	assign proc_load = !processor_addr_strobe_n && !chip_enable_one_n; // [R6]
	// The controller strobe only counts when the processor strobe is not being honoured.
	assign ctrl_load = !controller_addr_strobe_n && !proc_load; // [R13]
	assign load = proc_load || ctrl_load;
	assign active_q = (state_q != SBS_DESEL);
	// Enables matter only on a load; bursts keep the earlier selection.
	assign sel_next = load ? ce_ok : active_q; // [R1] [R10]
	assign advance = !load && active_q && !burst_advance_n; // [R5]

	// ============================================================
	// Write qualification

	assign bw_sel_n = {byte_lane_d_write_sel_n, byte_lane_c_write_sel_n, byte_lane_b_write_sel_n,
		byte_lane_a_write_sel_n};
	// Global write wins; otherwise byte selects need the byte write enable.
	assign lanes = !global_write_n ? {NL{1'b1}} : (!byte_write_enable_n ? ~bw_sel_n : {NL{1'b0}}); // [R3] [R4]
	// A processor-strobe edge always opens as a read; writes qualify on later edges.
	assign wr_now = sel_next && (lanes != {NL{1'b0}}) && !proc_load;
	assign rd_now = sel_next && !wr_now;
	assign first_clk = load && ce_ok && !active_q;
	assign state_d = !sel_next ? SBS_DESEL : (wr_now ? SBS_WRITE : SBS_READ);
	assign upper_next = (load && ce_ok) ? addr_upper : core_addr_q[AW-1:BURST_W]; // [R1]

	// ============================================================
	// Burst counter

	sbs_burst_ctr u_burst
	(
		.clk(clk),
		.nrst(nrst),
		.load(load && ce_ok), // [R2]
		.advance(advance),
		.start({addr_bit_one, addr_bit_zero}),
		.interleaved(interleaved_q),
		.low_next(low_next)
	);

	// ============================================================
	// Registers

	// The strap is caught once on the first clock after reset, never by the reset itself.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			strap_taken_q <= 1'b0;
			interleaved_q <= RST_STRAP;
		end
		else if (!strap_taken_q)
		begin
			strap_taken_q <= 1'b1;
			interleaved_q <= (burst_order_strap != ORDER_LINEAR); // [R14]
		end
	end

	// Access state and core requests for the edge just taken.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= SBS_DESEL;
			core_addr_q <= '0;
			core_byte_we_q <= '0;
			core_wdata_q <= '0;
			core_rd_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			core_addr_q <= {upper_next, low_next};
			core_byte_we_q <= wr_now ? lanes : {NL{1'b0}}; // [R3] [R4]
			core_wdata_q <= dq_in;
			core_rd_q <= rd_now;
			rd_pend_q <= rd_now && !first_clk; // [R12]
		end
	end

	// Pin drive lags the core read by one clock, so the enable is sampled here as well;
	// that costs a cycle of response against a truly asynchronous enable.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dq_out_q <= '0;
			dq_oe_n_q <= RST_OE_N;
		end
		else
		begin
			dq_out_q <= core_rdata;
			dq_oe_n_q <= !(rd_pend_q && !output_enable_n); // [R11] [R16]
		end
	end

	// ============================================================
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_new_select;
		load && ce_ok;
	endsequence

	sequence s_read_open;
		!active_q ##0 s_new_select ##0 !ctrl_load;
	endsequence

	a_addr_capture: assert property (s_new_select |=> core_addr_q[AW-1:BURST_W] == $past(addr_upper)) // [R1]
		else $error("upper address not captured on select");
	a_low_bits: assert property (s_new_select |=> core_addr_q[1:0] == $past({addr_bit_one, addr_bit_zero})) // [R2]
		else $error("low address bits not loaded into burst counter");
	a_byte_write: assert property (sel_next && !proc_load && global_write_n && !byte_write_enable_n // [R3]
		&& bw_sel_n != {NL{1'b1}} |=> core_byte_we_q == ~$past(bw_sel_n))
		else $error("byte lanes wrong for byte write");
	a_no_byte_write: assert property (global_write_n && byte_write_enable_n |=> core_byte_we_q == {NL{1'b0}}) // [R3]
		else $error("write without byte write enable");
	a_global_write: assert property (sel_next && !proc_load && !global_write_n |=> core_byte_we_q == {NL{1'b1}}) // [R4]
		else $error("global write did not hit all lanes");
	a_burst_step: assert property (advance && !interleaved_q && strap_taken_q // [R5]
		|=> core_addr_q[1:0] == BURST_W'($past(core_addr_q[1:0]) + 2'h1))
		else $error("linear burst did not step by one");
	a_proc_ignore: assert property (!processor_addr_strobe_n && chip_enable_one_n && controller_addr_strobe_n // [R6]
		&& !active_q |=> state_q == SBS_DESEL)
		else $error("processor strobe honoured with first enable high");
	a_ce_ignored: assert property (!load |=> (state_q != SBS_DESEL) == $past(active_q)) // [R10]
		else $error("selection changed without a load");
	a_first_mask: assert property (s_read_open ##0 !output_enable_n |=> ##1 dq_oe_n_q) // [R12]
		else $error("pins driven in first clock out of deselect");
	a_write_float: assert property (wr_now |=> ##1 dq_oe_n_q) // [R16]
		else $error("pins driven during write data");
	a_oe_follow: assert property (rd_pend_q && !output_enable_n |=> !dq_oe_n_q) // [R11]
		else $error("pins not driven on enabled read");
	// With both strobes low the edge must open as a read, whatever the write qualifiers say.
	a_strobe_prio: assert property (!processor_addr_strobe_n && !controller_addr_strobe_n && !chip_enable_one_n // [R13]
		&& ce_ok |=> core_rd_q && core_byte_we_q == {NL{1'b0}})
		else $error("controller strobe acted on beside processor strobe");
endmodule

// ==== dv/sbs_core_model.sv ====
`timescale 1ns/1ns
// ============================================================
// Memory core stand-in: read data is a fixed tag above the address.
module sbs_core_model
	import sbs_pkg::*;
(
	// Address in, data out
	input wire logic [ADDR_W-1:0] core_addr_q,
	output logic [LANES*LANE_W-1:0] core_rdata
);
	// The address is folded into the data, so a stale beat shows at once.
	assign core_rdata = {16'hC3C3, core_addr_q};
endmodule

// ==== dv/sync_burst_sram_port_control_tb.sv ====
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the burst SRAM port control.
module sync_burst_sram_port_control_tb;
	import sbs_pkg::*;
	logic clk = 0, nrst = 0, ps_n = 1, cs_n = 1, step_n = 1, lo_one = 0, lo_zero = 0;
	logic en1_n = 0, en2 = 1, en3_n = 0;
	logic bga = 0, strap = 0, all_wr_n = 1, bytes_en_n = 1, oe_n = 0;
	logic [3:0] sel_n = 4'hF;
	logic [17:0] upper = 18'h0;
	logic [35:0] dq_in = 36'h9A5A5A5A5, dq_out, wdata, rdata;
	logic [19:0] addr;
	logic [3:0] we;
	logic oe_q, rd;
	int failures = 0, num_checks = 0, cycles = 0;
	// Clock at 100 MHz.
	always #5 clk = ~clk;
	sbs_port_ctrl sbs_port_ctrl_inst (.clk(clk), .nrst(nrst), .addr_upper(upper), .addr_bit_one(lo_one),
		.addr_bit_zero(lo_zero), .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
		.burst_advance_n(step_n), .chip_enable_one_n(en1_n), .chip_enable_two(en2),
		.chip_enable_three_n(en3_n), .bga_package(bga), .burst_order_strap(strap), .global_write_n(all_wr_n),
		.byte_write_enable_n(bytes_en_n), .byte_lane_a_write_sel_n(sel_n[0]), .byte_lane_b_write_sel_n(sel_n[1]),
		.byte_lane_c_write_sel_n(sel_n[2]), .byte_lane_d_write_sel_n(sel_n[3]), .output_enable_n(oe_n),
		.dq_in(dq_in), .dq_out_q(dq_out), .dq_oe_n_q(oe_q), .core_addr_q(addr), .core_byte_we_q(we),
		.core_wdata_q(wdata), .core_rd_q(rd), .core_rdata(rdata));
	sbs_core_model sbs_core_model_inst (.core_addr_q(addr), .core_rdata(rdata));
	// Compare one value; an unknown matches only an unknown in the same bit.
	task chk(input string name, input logic [35:0] seen, input logic [35:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// A hang is cut short well past the 35 or so cycles the run needs.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			report_and_stop();
		end
	end
	task do_reset(input logic s);
		nrst = 0;
		strap = s;
		repeat (6) @(negedge clk);
		nrst = 1;
		repeat (2) @(negedge clk);
	endtask
	// One strobed edge; strobes stay as set so that back-to-back loads assign each pin once per step.
	task load(input logic p, input logic c, input logic [19:0] a);
		ps_n = p;
		cs_n = c;
		{upper, lo_one, lo_zero} = a;
		@(negedge clk);
	endtask
	// Lift both strobes before an edge that must not load.
	task release_strobes;
		ps_n = 1;
		cs_n = 1;
	endtask
	task burst_linear;
		load(0, 1, 20'h12343);
		release_strobes();
		chk("addr", addr, 20'h12343);
		chk("rd", rd, 1'h1);
		step_n = 0;
		@(negedge clk);
		chk("wrap", addr, 20'h12340);
		chk("oe first", oe_q, 1);
		@(negedge clk);
		chk("step", addr, 20'h12341);
		@(negedge clk);
		step_n = 1;
		chk("step2", addr, 20'h12342);
		chk("oe", oe_q, 0);
		chk("dout", dq_out, {16'hC3C3, 20'h12341});
	endtask
	task writes;
		all_wr_n = 0;
		load(1, 0, 20'h00010);
		all_wr_n = 1;
		chk("all lanes", we, 4'hF);
		chk("wdata", wdata, dq_in);
		release_strobes();
		@(negedge clk);
		chk("oe write", oe_q, 1'h1);
		bytes_en_n = 0;
		sel_n = 4'hA;
		load(1, 0, 20'h00011);
		chk("bw", we, 4'h5);
		bytes_en_n = 1;
		sel_n = 4'h0;
		load(1, 0, 20'h00012);
		chk("bw off", we, 4'h0);
		sel_n = 4'hF;
		all_wr_n = 0;
		load(0, 0, 20'h00013);
		all_wr_n = 1;
		chk("both rd", rd, 1'h1);
		chk("both we", we, 4'h0);
	endtask
	task selects;
		en1_n = 1;
		load(0, 1, 20'h00020);
		chk("ps ignored", addr, 20'h00013);
		load(0, 0, 20'h00021);
		release_strobes();
		en1_n = 0;
		chk("desel", rd, 1'h0);
		step_n = 0;
		@(negedge clk);
		step_n = 1;
		chk("held", rd, 1'h0);
		chk("oe desel", oe_q, 1'h1);
		// Processor strobe alone with the first enable high while deselected must not select.
		en1_n = 1;
		load(0, 1, 20'h00022);
		chk("ps ignored desel", rd, 1'h0);
		en1_n = 0;
		en3_n = 1;
		load(0, 1, 20'h00030);
		chk("third enable", rd, 1'h0);
		bga = 1;
		load(0, 1, 20'h00031);
		chk("bga", rd, 1'h1);
		release_strobes();
		bga = 0;
		en3_n = 0;
	endtask
	task burst_interleaved;
		do_reset(1);
		load(0, 1, 20'h00AC1);
		release_strobes();
		step_n = 0;
		@(negedge clk);
		chk("il1", addr, 20'h00AC0);
		@(negedge clk);
		chk("il2", addr, 20'h00AC3);
		@(negedge clk);
		step_n = 1;
		chk("il3", addr, 20'h00AC2);
	endtask
	initial
	begin
		do_reset(0);
		burst_linear();
		writes();
		selects();
		burst_interleaved();
		report_and_stop();
	end
endmodule
